// ---- src/urdr_rx.sv ----
// What this block does
// - sample input at sixteen ticks per bit
// - realign slot counter on every start edge
// - realign on high-to-low data bit change
// - start edge is low after three highs
// - slots 3/5/7 verify start, flag noise
// - failed start check resets counter, resumes hunt
// - data bit is majority of slots 8-10
// - start slots 8-10 only flag noise
// - stop low majority sets framing error
// - rejected glitch never sets noise flag
// - start noise burst keeps slot counter running
// - missing stop or break sets framing error
// - framing error rises with receive-full flag
// - realign on valid falling edges within frame
// - select eight or nine data bits
// - finished frame loads buffer, sets full flag
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "urdr_defines.svh"

module urdr_rx #(
  parameter int ADDR_W = 12
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rx_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rx_full_flag,
  output logic framing_error_flag,
  output logic noise_flag,
  output logic rx_ninth_bit
);

  urdr_pkg::urdr_ctrl_s ctrl_q;
  urdr_pkg::urdr_stat_s stat_q;
  urdr_pkg::urdr_frame_s frame;
  urdr_pkg::urdr_state_e state_q;
  logic [`URDR_DIV_W-1:0] div_q;
  logic [`URDR_DIV_W-1:0] div_cnt_q;
  logic tick_q;
  logic rx_meta_q;
  logic rx_sync_q;
  logic [2:0] hist_q;
  logic [4:0] slot_q;
  logic [1:0] ver_q;
  logic [1:0] dat_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic [8:0] data_q;
  logic pend_nf_q;
  logic cur_hi_q;
  logic prev_hi_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic samp;
  logic vote;
  logic split;
  logic edge_ok;
  logic [1:0] ones;
  logic [3:0] last_bit;
  logic setup;
  logic access;
  logic wr_ctrl;
  logic wr_div;
  logic rd_data;
  logic mapped;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_full_flag = stat_q.full;
  assign framing_error_flag = stat_q.framing;
  assign noise_flag = stat_q.noise;
  assign rx_ninth_bit = data_q[8];

  // receive pin crosses into pclk domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end
    else
    begin
      rx_meta_q <= rx_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  // oversample tick every div_q pclk cycles, stopped while div_q is zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (div_q == '0)
    begin
      div_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (div_cnt_q >= div_q - 1'b1)
    begin
      div_cnt_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  always_comb
  begin
    samp = rx_sync_q;
    vote = (dat_q[0] & dat_q[1]) | (dat_q[0] & samp) | (dat_q[1] & samp);
    split = !((dat_q[0] == dat_q[1]) && (dat_q[1] == samp));
    ones = 2'(ver_q[0]) + 2'(ver_q[1]) + 2'(samp);
    edge_ok = !samp && (hist_q == 3'b111);
    last_bit = ctrl_q.nine_bit ? `URDR_BITS_LONG : `URDR_BITS_SHORT;
    frame.done = tick_q && (state_q == urdr_pkg::URDR_STOP) && (slot_q == `URDR_SLOT_D3);
    frame.fe = !vote;
    frame.nf = pend_nf_q | split;
    frame.data = ctrl_q.nine_bit ? shift_q : {1'b0, shift_q[8:1]};
  end

  // data recovery sequencer, advances on oversample ticks only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= urdr_pkg::URDR_HUNT;
      hist_q <= 3'b000;
      slot_q <= `URDR_SLOT_FIRST;
      ver_q <= 2'b00;
      dat_q <= 2'b00;
      bit_q <= 4'h0;
      shift_q <= 9'h000;
      pend_nf_q <= 1'b0;
      cur_hi_q <= 1'b0;
      prev_hi_q <= 1'b0;
    end
    else if (!ctrl_q.enable)
    begin
      state_q <= urdr_pkg::URDR_HUNT;
      hist_q <= 3'b000;
      slot_q <= `URDR_SLOT_FIRST;
    end
    else if (tick_q)
    begin
      hist_q <= {hist_q[1:0], samp};
      slot_q <= (slot_q == `URDR_SLOT_LAST) ? `URDR_SLOT_FIRST : slot_q + 1'b1;
      if (slot_q == `URDR_SLOT_D1)
        dat_q[0] <= samp;
      if (slot_q == `URDR_SLOT_D2)
        dat_q[1] <= samp;
      unique case (state_q)
        urdr_pkg::URDR_HUNT:
        begin
          slot_q <= `URDR_SLOT_FIRST;
          if (edge_ok)
          begin
            state_q <= urdr_pkg::URDR_START;
            slot_q <= `URDR_SLOT_AFTER_EDGE;
            pend_nf_q <= 1'b0;
          end
        end
        urdr_pkg::URDR_START:
        begin
          if (slot_q == `URDR_SLOT_V1)
            ver_q[0] <= samp;
          if (slot_q == `URDR_SLOT_V2)
            ver_q[1] <= samp;
          if (slot_q == `URDR_SLOT_V3)
          begin
            if (ones > 2'd1)
            begin
              state_q <= urdr_pkg::URDR_HUNT;
              slot_q <= `URDR_SLOT_FIRST;
            end
            else if (ones == 2'd1)
              pend_nf_q <= 1'b1;
          end
          if (slot_q == `URDR_SLOT_D3 && (dat_q != 2'b00 || samp))
            pend_nf_q <= 1'b1;
          if (slot_q == `URDR_SLOT_LAST)
          begin
            state_q <= urdr_pkg::URDR_DATA;
            bit_q <= 4'h0;
            cur_hi_q <= 1'b0;
            prev_hi_q <= 1'b0;
          end
        end
        urdr_pkg::URDR_DATA:
        begin
          if (slot_q == `URDR_SLOT_D3)
          begin
            shift_q <= {vote, shift_q[8:1]};
            cur_hi_q <= vote;
            if (split)
              pend_nf_q <= 1'b1;
          end
          if (slot_q > `URDR_SLOT_D3 && cur_hi_q && edge_ok)
          begin
            slot_q <= `URDR_SLOT_AFTER_EDGE;
            bit_q <= bit_q + 1'b1;
            prev_hi_q <= 1'b1;
            cur_hi_q <= 1'b0;
            if (bit_q + 1'b1 == last_bit)
              state_q <= urdr_pkg::URDR_STOP;
          end
          else if (slot_q < `URDR_SLOT_D1 && prev_hi_q && edge_ok)
            slot_q <= `URDR_SLOT_AFTER_EDGE;
          else if (slot_q == `URDR_SLOT_LAST)
          begin
            bit_q <= bit_q + 1'b1;
            prev_hi_q <= cur_hi_q;
            cur_hi_q <= 1'b0;
            if (bit_q + 1'b1 == last_bit)
              state_q <= urdr_pkg::URDR_STOP;
          end
        end
        urdr_pkg::URDR_STOP:
        begin
          if (slot_q < `URDR_SLOT_D1 && prev_hi_q && edge_ok)
            slot_q <= `URDR_SLOT_AFTER_EDGE;
          if (slot_q == `URDR_SLOT_D3)
          begin
            state_q <= urdr_pkg::URDR_HUNT;
            slot_q <= `URDR_SLOT_FIRST;
          end
        end
      endcase
    end
  end

  // apb decode: one wait-free access phase, pready answers in it
  always_comb
  begin
    setup = psel && !penable;
    access = psel && penable && pready_q;
    mapped = (paddr == `URDR_CTRL_OFS) || (paddr == `URDR_DIV_OFS)
      || (paddr == `URDR_STAT_OFS) || (paddr == `URDR_DATA_OFS);
    wr_ctrl = access && pwrite && (paddr == `URDR_CTRL_OFS);
    wr_div = access && pwrite && (paddr == `URDR_DIV_OFS);
    rd_data = access && !pwrite && (paddr == `URDR_DATA_OFS);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite)
      begin
        prdata_q <= 32'h0000_0000;
        if (paddr == `URDR_CTRL_OFS)
          prdata_q[1:0] <= ctrl_q;
        if (paddr == `URDR_DIV_OFS)
          prdata_q[`URDR_DIV_W-1:0] <= div_q;
        if (paddr == `URDR_STAT_OFS)
          prdata_q[2:0] <= stat_q;
        if (paddr == `URDR_DATA_OFS)
          prdata_q[8:0] <= data_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `URDR_CTRL_RST;
      div_q <= `URDR_DIV_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[1:0];
      if (wr_div)
        div_q <= pwdata[`URDR_DIV_W-1:0];
    end
  end

  // frame result: a new frame wins over a clearing read in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= 3'b000;
      data_q <= 9'h000;
    end
    else if (frame.done)
    begin
      data_q <= frame.data;
      stat_q.full <= 1'b1;
      stat_q.framing <= frame.fe;
      stat_q.noise <= frame.nf;
    end
    else if (rd_data)
      stat_q <= 3'b000;
  end

endmodule

// ---- src/urdr_defines.svh ----
`ifndef URDR_DEFINES_SVH
`define URDR_DEFINES_SVH

// register byte offsets
`define URDR_CTRL_OFS 12'h000
`define URDR_DIV_OFS 12'h004
`define URDR_STAT_OFS 12'h008
`define URDR_DATA_OFS 12'h00c

// control register fields
`define URDR_CTRL_EN_BIT 0
`define URDR_CTRL_NINE_BIT 1
`define URDR_CTRL_RST 2'h0

// oversample divider register
`define URDR_DIV_W 16
`define URDR_DIV_RST 16'h0000

// status register fields
`define URDR_STAT_FULL_BIT 0
`define URDR_STAT_FE_BIT 1
`define URDR_STAT_NF_BIT 2

// oversample slot numbers within one bit time
`define URDR_SLOT_FIRST 5'd1
`define URDR_SLOT_AFTER_EDGE 5'd2
`define URDR_SLOT_V1 5'd3
`define URDR_SLOT_V2 5'd5
`define URDR_SLOT_V3 5'd7
`define URDR_SLOT_D1 5'd8
`define URDR_SLOT_D2 5'd9
`define URDR_SLOT_D3 5'd10
`define URDR_SLOT_LAST 5'd16

// data bits per character
`define URDR_BITS_SHORT 4'd8
`define URDR_BITS_LONG 4'd9

`endif

// ---- src/urdr_pkg.sv ----
package urdr_pkg;

  typedef enum logic [1:0] {
    URDR_HUNT,
    URDR_START,
    URDR_DATA,
    URDR_STOP
  } urdr_state_e;

  typedef struct packed {
    logic nine_bit;
    logic enable;
  } urdr_ctrl_s;

  typedef struct packed {
    logic noise;
    logic framing;
    logic full;
  } urdr_stat_s;

  typedef struct packed {
    logic done;
    logic fe;
    logic nf;
    logic [8:0] data;
  } urdr_frame_s;

endpackage

// ---- sim/urdr_props.sv ----
`timescale 1ns/1ps
module urdr_props #(
  parameter int ADDR_W = 12
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rx_in,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_full_flag,
  input wire logic framing_error_flag,
  input wire logic noise_flag,
  input wire logic rx_ninth_bit
);
  wire logic rd_hit = psel && penable && pready && !pwrite && paddr == 12'h00c;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  a_ready_setup: assert property (s_setup |=> pready)
    else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  sequence s_fe_drop;
    $fell(framing_error_flag);
  endsequence
  a_fe_full: assert property ($rose(framing_error_flag) |-> rx_full_flag)
    else $error("framing flag without full flag");
  a_nf_full: assert property ($rose(noise_flag) |-> rx_full_flag)
    else $error("noise flag outside frame end");
  a_ninth_full: assert property ($rose(rx_ninth_bit) |-> rx_full_flag)
    else $error("ninth bit outside frame end");
  a_full_read: assert property ($fell(rx_full_flag) |-> $past(rd_hit))
    else $error("full flag cleared without read");
  a_fe_read: assert property (s_fe_drop |-> $past(rd_hit) || rx_full_flag)
    else $error("framing flag lost");
endmodule
bind urdr_rx urdr_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .rx_in(rx_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_full_flag(rx_full_flag), .framing_error_flag(framing_error_flag),
  .noise_flag(noise_flag), .rx_ninth_bit(rx_ninth_bit));

// ---- sim/urdr_tx_model.sv ----
`timescale 1ns/1ps
module urdr_tx_model (
  input wire logic pclk,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // nw cycles from cycle nz are inverted to model line noise
  task automatic send(input logic [8:0] d, input int n, input logic stp, input int bl,
    input int nz, input int nw);
    logic [10:0] f;
    int c;
    f = {1'b1, d, 1'b0};
    f[n + 1] = stp;
    c = 0;
    for (int b = 0; b < n + 2; b++)
    begin
      repeat (bl)
      begin
        @(posedge pclk);
        rx_line <= f[b] ^ (c >= nz && c < nz + nw);
        c++;
      end
    end
    @(posedge pclk);
    rx_line <= 1'b1;
  endtask
  task automatic dip(input int k);
    @(posedge pclk);
    rx_line <= 1'b0;
    repeat (k) @(posedge pclk);
    rx_line <= 1'b1;
  endtask
endmodule

// ---- sim/urdr_rx_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      error_cnt++; \
      $display("Error t=%0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module urdr_rx_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, rx_full_flag, framing_error_flag, noise_flag, rx_ninth_bit;
  logic rx_in, er;
  int error_cnt = 0;
  int n_checks = 0;
  always #50 pclk = ~pclk;
  urdr_rx uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_in(rx_in), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_full_flag(rx_full_flag),
    .framing_error_flag(framing_error_flag), .noise_flag(noise_flag),
    .rx_ninth_bit(rx_ninth_bit));
  urdr_tx_model tx (.pclk(pclk), .rx_line(rx_in));
  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(negedge pclk);
    `CHK(pready, 1'b1);
    if (pready !== 1'b1) test_done();
    @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask
  task automatic rx_chk(input logic [8:0] d, input logic fe, input logic nf);
    int i;
    @(negedge pclk);
    for (i = 0; i < 40 && rx_full_flag !== 1'b1; i++) @(negedge pclk);
    `CHK(rx_full_flag, 1'b1);
    if (rx_full_flag !== 1'b1) test_done();
    `CHK({framing_error_flag, noise_flag}, {fe, nf});
    `CHK(rx_ninth_bit, d[8]);
    rchk(12'h00c, {23'h0, d});
    rchk(12'h008, 32'h0);
  endtask
  task automatic t_regs();
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h0);
    rchk(12'h008, 32'h0);
    rchk(12'h010, 32'h0);
    `CHK(er, 1'b1);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    rchk(12'h004, 32'h1);
    `CHK(er, 1'b0);
    rchk(12'h000, 32'h1);
  endtask
  task automatic t_frames();
    tx.send(9'h0a5, 8, 1'b1, 16, -1, 0);
    rx_chk(9'h0a5, 1'b0, 1'b0);
    tx.send(9'h03c, 8, 1'b0, 16, -1, 0);
    rx_chk(9'h03c, 1'b1, 1'b0);
    tx.send(9'h000, 8, 1'b0, 16, -1, 0);
    rx_chk(9'h000, 1'b1, 1'b0);
  endtask
  task automatic t_noise();
    int nz[4] = '{2, 7, 24, 152};
    int nw[4] = '{1, 3, 1, 1};
    foreach (nz[k])
    begin
      tx.send(9'h0a5, 8, 1'b1, 16, nz[k], nw[k]);
      rx_chk(9'h0a5, 1'b0, 1'b1);
    end
  endtask
  task automatic t_glitch();
    tx.dip(3);
    repeat (200) @(negedge pclk);
    `CHK({rx_full_flag, noise_flag}, 2'b00);
    tx.send(9'h05a, 8, 1'b1, 16, -1, 0);
    rx_chk(9'h05a, 1'b0, 1'b0);
  endtask
  task automatic t_drift();
    int bl[2] = '{17, 15};
    foreach (bl[k])
    begin
      tx.send(9'h055, 8, 1'b1, bl[k], -1, 0);
      rx_chk(9'h055, 1'b0, 1'b0);
    end
  endtask
  task automatic t_nine();
    apb(1'b1, 12'h000, 32'h3);
    tx.send(9'h1a5, 9, 1'b1, 16, -1, 0);
    rx_chk(9'h1a5, 1'b0, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_frames();
    t_noise();
    t_glitch();
    t_drift();
    t_nine();
    test_done();
  end
endmodule
